/* core/pbaf_port_b.sv */
// Port B alternate-function override logic: timers, serial unit, pin change.
//
// Overview of operation
// - Bit 7 value is timer2 compare A when enabled; drives only if direction set.
// - Bit 6 value is timer1 compare B when enabled; drives only if direction set.
// - Bit 5 value is timer1 compare A when enabled; drives only if direction set.
// - Bit 4 value is timer0 compare A when enabled; drives only if direction set.
// - Bit 3 is input as master; as slave direction bit rules, slave output drives.
// - Bit 2 is input as slave; as master direction bit rules, master output drives.
// - Bit 1 is input as slave; as master direction bit rules, clock output drives.
// - Bit 0 is input as slave; as master only direction bit rules, no value.
// - Slave unit is active only while select pin is low; pin feeds select.
// - When serial role forces bits 3..0 input, pull-up follows port output bit unless the global disable is set.
// - Bit 3 joins master input and slave output; bit 2 the reverse.
// - Bits 7..0 feed pin change 15..8; masked and group enabled forces input on.
// - Master drives clock out on bit 1; slave receives clock from bit 1.
// - Value override enable picks override value, otherwise port output bit.
// - Direction override enable picks override value, ignoring direction bit.
// - Plain pull-up is on only for direction 0, output 1, disable 0.
// - Input enable override sets input buffer regardless of sleep state.
`timescale 1ns/1ps
`default_nettype none
`include "pbaf_consts.svh"

module pbaf_port_b (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Port register bits and global controls
  input wire logic [`PBAF_PORT_W-1:0] i_portb_dir,
  input wire logic [`PBAF_PORT_W-1:0] i_portb_out,
  input wire logic i_global_pullup_disable,
  input wire logic i_sleep_inputs_off,
  // Pad input levels
  input wire logic [`PBAF_PORT_W-1:0] i_pad_in,
  // Timer compare outputs
  input wire logic i_timer2_compare_a_en,
  input wire logic i_timer2_compare_a_out,
  input wire logic i_timer1_compare_b_en,
  input wire logic i_timer1_compare_b_out,
  input wire logic i_timer1_compare_a_en,
  input wire logic i_timer1_compare_a_out,
  input wire logic i_timer0_compare_a_en,
  input wire logic i_timer0_compare_a_out,
  // Serial peripheral unit
  input wire logic i_spi_unit_enable,
  input wire logic i_spi_master_select,
  input wire logic i_spi_slave_out,
  input wire logic i_spi_master_out,
  input wire logic i_spi_sck_out,
  // Pin change interrupt controls
  input wire logic [`PBAF_PORT_W-1:0] i_pin_change_mask,
  input wire logic i_pin_change_group1_enable,
  // Pad controls
  output logic [`PBAF_PORT_W-1:0] o_pad_out,
  output logic [`PBAF_PORT_W-1:0] o_pad_oe,
  output logic [`PBAF_PORT_W-1:0] o_pad_pullup,
  output logic [`PBAF_PORT_W-1:0] o_pad_in_en,
  // Digital inputs to the alternate functions
  output logic [`PBAF_PORT_W-1:0] o_pin_change_src,
  output var logic o_spi_master_in,
  output var logic o_spi_slave_in,
  output var logic o_spi_sck_in,
  output var logic o_spi_select_n
);

  // ==========================================================
  // Serial unit role
  // ==========================================================
  pbaf_pkg::pbaf_spi_role_t role;
  logic is_master;
  logic is_slave;

  always_comb begin
    if (!i_spi_unit_enable) begin
      role = pbaf_pkg::PBAF_SPI_OFF;
    end else if (i_spi_master_select) begin
      role = pbaf_pkg::PBAF_SPI_MASTER;
    end else begin
      role = pbaf_pkg::PBAF_SPI_SLAVE;
    end
    is_master = 1'b0;
    is_slave = 1'b0;
    case (role)
      pbaf_pkg::PBAF_SPI_MASTER: begin
        is_master = 1'b1;
      end
      pbaf_pkg::PBAF_SPI_SLAVE: begin
        is_slave = 1'b1;
      end
      default: begin
        is_master = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Override bundles from the alternate functions
  // ==========================================================
  pbaf_pkg::pbaf_ovr_t ovr [`PBAF_PORT_W];
  logic spi_pullup [`PBAF_PORT_W];

  always_comb begin
    for (int b = 0; b < `PBAF_PORT_W; b++) begin
      ovr[b] = `PBAF_OVR_NONE;
      spi_pullup[b] = i_portb_out[b] & ~i_global_pullup_disable;
      ovr[b].input_enable_override_enable = i_pin_change_mask[b]
                                            & i_pin_change_group1_enable;
      ovr[b].input_enable_override_value = 1'b1;
    end
    ovr[`PBAF_BIT_T2A].pin_value_override_enable = i_timer2_compare_a_en;
    ovr[`PBAF_BIT_T2A].pin_value_override_value = i_timer2_compare_a_out;
    ovr[`PBAF_BIT_T1B].pin_value_override_enable = i_timer1_compare_b_en;
    ovr[`PBAF_BIT_T1B].pin_value_override_value = i_timer1_compare_b_out;
    ovr[`PBAF_BIT_T1A].pin_value_override_enable = i_timer1_compare_a_en;
    ovr[`PBAF_BIT_T1A].pin_value_override_value = i_timer1_compare_a_out;
    ovr[`PBAF_BIT_T0A].pin_value_override_enable = i_timer0_compare_a_en;
    ovr[`PBAF_BIT_T0A].pin_value_override_value = i_timer0_compare_a_out;
    // Data in towards a master, data out as a slave.
    ovr[`PBAF_BIT_MISO].pullup_override_enable = is_master;
    ovr[`PBAF_BIT_MISO].pullup_override_value = spi_pullup[`PBAF_BIT_MISO];
    ovr[`PBAF_BIT_MISO].direction_override_enable = is_master;
    ovr[`PBAF_BIT_MISO].pin_value_override_enable = is_slave;
    ovr[`PBAF_BIT_MISO].pin_value_override_value = i_spi_slave_out;
    // Data out from a master, data in to a slave.
    ovr[`PBAF_BIT_MOSI].pullup_override_enable = is_slave;
    ovr[`PBAF_BIT_MOSI].pullup_override_value = spi_pullup[`PBAF_BIT_MOSI];
    ovr[`PBAF_BIT_MOSI].direction_override_enable = is_slave;
    ovr[`PBAF_BIT_MOSI].pin_value_override_enable = is_master;
    ovr[`PBAF_BIT_MOSI].pin_value_override_value = i_spi_master_out;
    ovr[`PBAF_BIT_SCK].pullup_override_enable = is_slave;
    ovr[`PBAF_BIT_SCK].pullup_override_value = spi_pullup[`PBAF_BIT_SCK];
    ovr[`PBAF_BIT_SCK].direction_override_enable = is_slave;
    ovr[`PBAF_BIT_SCK].pin_value_override_enable = is_master;
    ovr[`PBAF_BIT_SCK].pin_value_override_value = i_spi_sck_out;
    ovr[`PBAF_BIT_SS].pullup_override_enable = is_slave;
    ovr[`PBAF_BIT_SS].pullup_override_value = spi_pullup[`PBAF_BIT_SS];
    ovr[`PBAF_BIT_SS].direction_override_enable = is_slave;
  end

  // ==========================================================
  // Per-pin merge of port bits and overrides
  // ==========================================================
  pbaf_pkg::pbaf_pad_t pad [`PBAF_PORT_W];
  pbaf_pkg::pbaf_pad_t next_pad [`PBAF_PORT_W];
  logic [`PBAF_PORT_W-1:0] next_din;

  for (genvar g = 0; g < `PBAF_PORT_W; g++) begin : g_pin
    always_comb begin
      if (ovr[g].direction_override_enable) begin
        next_pad[g].oe = ovr[g].direction_override_value;
      end else begin
        next_pad[g].oe = i_portb_dir[g];
      end
      if (ovr[g].pin_value_override_enable) begin
        next_pad[g].val = ovr[g].pin_value_override_value;
      end else begin
        next_pad[g].val = i_portb_out[g];
      end
      if (ovr[g].pullup_override_enable) begin
        next_pad[g].pu = ovr[g].pullup_override_value;
      end else begin
        next_pad[g].pu = ~i_portb_dir[g] & i_portb_out[g]
                         & ~i_global_pullup_disable;
      end
      if (ovr[g].input_enable_override_enable) begin
        next_pad[g].ie = ovr[g].input_enable_override_value;
      end else begin
        next_pad[g].ie = ~i_sleep_inputs_off;
      end
      // A disabled input buffer reads low so a floating pad cannot toggle logic.
      next_din[g] = i_pad_in[g] & next_pad[g].ie;
    end

    always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
        pad[g] <= `PBAF_RST_PAD;
        o_pin_change_src[g] <= `PBAF_RST_IN;
      end else begin
        pad[g] <= next_pad[g];
        o_pin_change_src[g] <= next_din[g];
      end
    end

    assign o_pad_oe[g] = pad[g].oe;
    assign o_pad_out[g] = pad[g].val;
    assign o_pad_pullup[g] = pad[g].pu;
    assign o_pad_in_en[g] = pad[g].ie;
  end

  // ==========================================================
  // Digital inputs handed to the serial unit
  // ==========================================================
  logic next_master_in;
  logic next_slave_in;
  logic next_sck_in;
  logic next_select_n;

  always_comb begin
    next_master_in = next_din[`PBAF_BIT_MISO];
    next_slave_in = next_din[`PBAF_BIT_MOSI];
    next_sck_in = next_din[`PBAF_BIT_SCK];
    // Select reads idle while its buffer is off, so in sleep only a select armed for pin change can wake a slave.
    next_select_n = next_din[`PBAF_BIT_SS] | ~next_pad[`PBAF_BIT_SS].ie;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_spi_master_in <= `PBAF_RST_IN;
      o_spi_slave_in <= `PBAF_RST_IN;
      o_spi_sck_in <= `PBAF_RST_IN;
      o_spi_select_n <= `PBAF_RST_SEL_N;
    end else begin
      o_spi_master_in <= next_master_in;
      o_spi_slave_in <= next_slave_in;
      o_spi_sck_in <= next_sck_in;
      o_spi_select_n <= next_select_n;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  sequence s_master;
    i_spi_unit_enable && i_spi_master_select;
  endsequence

  sequence s_slave;
    i_spi_unit_enable && !i_spi_master_select;
  endsequence

  sequence s_pc_armed(int b);
    i_pin_change_mask[b] && i_pin_change_group1_enable;
  endsequence

  chk_t2_value: assert property (
    i_timer2_compare_a_en |=> o_pad_out[7] == $past(i_timer2_compare_a_out)
      && o_pad_oe[7] == $past(i_portb_dir[7]))
    else $error("bit 7 does not carry timer2 compare A");

  chk_t1b_value: assert property (
    i_timer1_compare_b_en |=> o_pad_out[6] == $past(i_timer1_compare_b_out)
      && o_pad_oe[6] == $past(i_portb_dir[6]))
    else $error("bit 6 does not carry timer1 compare B");

  chk_t1a_value: assert property (
    i_timer1_compare_a_en |=> o_pad_out[5] == $past(i_timer1_compare_a_out)
      && o_pad_oe[5] == $past(i_portb_dir[5]))
    else $error("bit 5 does not carry timer1 compare A");

  chk_t0a_value: assert property (
    i_timer0_compare_a_en |=> o_pad_out[4] == $past(i_timer0_compare_a_out)
      && o_pad_oe[4] == $past(i_portb_dir[4]))
    else $error("bit 4 does not carry timer0 compare A");

  chk_port_value: assert property (
    !i_timer2_compare_a_en && !i_spi_unit_enable
      |=> o_pad_out[7] == $past(i_portb_out[7])
      && o_pad_out[3:0] == $past(i_portb_out[3:0]))
    else $error("port bit value not passed without override");

  chk_miso_master: assert property (
    s_master |=> !o_pad_oe[3] && o_spi_master_in == ($past(i_pad_in[3]) & o_pad_in_en[3]))
    else $error("data-in pin not forced to input as master");

  chk_miso_slave: assert property (
    s_slave |=> o_pad_oe[3] == $past(i_portb_dir[3])
      && o_pad_out[3] == $past(i_spi_slave_out))
    else $error("slave data not driven on bit 3");

  chk_mosi_slave: assert property (
    s_slave |=> !o_pad_oe[2] && o_spi_slave_in == ($past(i_pad_in[2]) & o_pad_in_en[2]))
    else $error("data-out pin not forced to input as slave");

  chk_mosi_master: assert property (
    s_master |=> o_pad_oe[2] == $past(i_portb_dir[2])
      && o_pad_out[2] == $past(i_spi_master_out))
    else $error("master data not driven on bit 2");

  chk_sck_master: assert property (
    s_master ##1 s_master |=> o_pad_out[1] == $past(i_spi_sck_out)
      && $past(o_pad_out[1]) == $past(i_spi_sck_out, 2))
    else $error("serial clock not driven on bit 1 as master");

  chk_sck_slave: assert property (
    s_slave |=> !o_pad_oe[1] && o_spi_sck_in == ($past(i_pad_in[1]) & o_pad_in_en[1]))
    else $error("serial clock not taken from bit 1 as slave");

  chk_ss_slave: assert property (
    s_slave |=> !o_pad_oe[0])
    else $error("select pin not forced to input as slave");

  chk_ss_master: assert property (
    s_master |=> o_pad_oe[0] == $past(i_portb_dir[0])
      && o_pad_out[0] == $past(i_portb_out[0]))
    else $error("select pin wrongly overridden as master");

  chk_ss_select: assert property (
    ##1 o_spi_select_n == ($past(i_pad_in[0]) | !o_pad_in_en[0]))
    else $error("select input does not follow the pin");

  chk_spi_pullup: assert property (
    s_slave |=> o_pad_pullup[2:0]
      == ($past(i_portb_out[2:0]) & {3{!$past(i_global_pullup_disable)}}))
    else $error("forced-input pull-up does not follow port bit");

  chk_miso_pullup: assert property (
    s_master |=> o_pad_pullup[3]
      == ($past(i_portb_out[3]) && !$past(i_global_pullup_disable)))
    else $error("data-in pull-up ignores the disable bit");

  chk_plain_pullup: assert property (
    1'b1 |=> o_pad_pullup[7:4]
      == (~$past(i_portb_dir[7:4]) & $past(i_portb_out[7:4])
      & {4{!$past(i_global_pullup_disable)}}))
    else $error("plain pull-up condition wrong");

  chk_pc_wake: assert property (
    s_pc_armed(7) |=> o_pad_in_en[7] && o_pin_change_src[7] == $past(i_pad_in[7]))
    else $error("armed pin change input not forced on");

  chk_sleep_off: assert property (
    i_sleep_inputs_off && !i_pin_change_mask[5]
      |=> !o_pad_in_en[5] && !o_pin_change_src[5])
    else $error("input buffer not shut in sleep");

  chk_dir_hold: assert property (
    s_master [*2] |=> !o_pad_oe[3] && !$past(o_pad_oe[3]))
    else $error("direction override lost while master");

endmodule

`default_nettype wire

/* core/pbaf_consts.svh */
// Constants for the port B alternate-function override block.
`ifndef PBAF_CONSTS_SVH
`define PBAF_CONSTS_SVH

// ==========================================================
// Pin positions of the alternate functions
// ==========================================================
`define PBAF_PORT_W 8
`define PBAF_BIT_SS 0
`define PBAF_BIT_SCK 1
`define PBAF_BIT_MOSI 2
`define PBAF_BIT_MISO 3
`define PBAF_BIT_T0A 4
`define PBAF_BIT_T1A 5
`define PBAF_BIT_T1B 6
`define PBAF_BIT_T2A 7

// ==========================================================
// Reset values and the empty override bundle
// ==========================================================
`define PBAF_RST_PAD 4'h0
`define PBAF_RST_IN 1'h0
`define PBAF_RST_SEL_N 1'h1
`define PBAF_OVR_NONE 8'h00

`endif

/* core/pbaf_pkg.sv */
// Types shared by the port B alternate-function override block.
`default_nettype none
package pbaf_pkg;

  // ==========================================================
  // Override bundle that an alternate function hands to a pin
  // ==========================================================
  typedef struct packed {
    logic pullup_override_enable;
    logic pullup_override_value;
    logic direction_override_enable;
    logic direction_override_value;
    logic pin_value_override_enable;
    logic pin_value_override_value;
    logic input_enable_override_enable;
    logic input_enable_override_value;
  } pbaf_ovr_t;

  // ==========================================================
  // Final pad controls of one pin
  // ==========================================================
  typedef struct packed {
    logic oe;
    logic val;
    logic pu;
    logic ie;
  } pbaf_pad_t;

  // ==========================================================
  // Role of the serial peripheral unit
  // ==========================================================
  typedef enum logic [1:0] {
    PBAF_SPI_OFF = 2'b00,
    PBAF_SPI_SLAVE = 2'b01,
    PBAF_SPI_MASTER = 2'b10
  } pbaf_spi_role_t;

endpackage

`default_nettype wire

/* testbench/pbaf_far_model.sv */
// Far-side model: timer waveforms and a serial unit that feed the port override block.
`timescale 1ns/1ps
`default_nettype none

module pbaf_far_model (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Serial unit role and select level seen at the pin
  input wire logic i_spi_master_select,
  input wire logic i_spi_select_n,
  // Timer waveforms: bit 3 timer 2 A, bit 2 timer 1 B, bit 1 timer 1 A, bit 0 timer 0 A
  output logic [3:0] o_timer_wave,
  // Serial unit outputs
  output logic o_spi_master_out,
  output logic o_spi_sck_out,
  output var logic o_spi_slave_out
);
  logic [7:0] cnt;
  logic [7:0] shreg;

  // ==========================================================
  // Waveforms
  // ==========================================================
  assign o_timer_wave = {cnt[0], cnt[1], cnt[2], cnt[3:0] < 4'h5};
  // The clock stands still unless the unit is master.
  assign o_spi_sck_out = i_spi_master_select & cnt[0];
  assign o_spi_master_out = i_spi_master_select & shreg[7];

  // ==========================================================
  // Shifter
  // ==========================================================
  // Updates land on the falling edge so the block samples settled levels.
  always @(negedge i_clk_sys) begin
    if (i_reset) begin
      cnt <= 8'h00;
      shreg <= 8'ha5;
      o_spi_slave_out <= 1'b0;
    end else begin
      cnt <= cnt + 8'h01;
      if (i_spi_master_select && cnt[0]) begin
        shreg <= {shreg[6:0], shreg[7]};
      end
      if (!i_spi_master_select && !i_spi_select_n) begin
        shreg <= {shreg[6:0], shreg[7]};
        o_spi_slave_out <= shreg[7];
      end else begin
        // Unless selected as a slave, the line toggles on every falling edge instead of holding stale data.
        o_spi_slave_out <= ~o_spi_slave_out;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the port B alternate-function override block.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] dir = 8'h00;
  logic [7:0] out = 8'h00;
  logic [7:0] ext = 8'h00;
  logic [7:0] mask = 8'h00;
  logic [3:0] ten = 4'h0;
  logic pull_off = 1'b0;
  logic sleep = 1'b0;
  logic spi_on = 1'b0;
  logic spi_master = 1'b0;
  logic g1 = 1'b0;
  logic ev = 1'b0;
  logic [40:0] exp_q;
  logic [3:0] tw;
  logic m_out, s_out, sck_out;
  logic [7:0] pad_out, pad_oe, pad_pu, pad_ie, pcs, pad_in;
  logic m_in, s_in, sck_in, sel_n;
  int miscompares = 0;
  int checks_done = 0;

  always #2 clk = ~clk;

  // Undriven pins follow the external level; driven pins read back their own value.
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);

  pbaf_far_model far (.i_clk_sys(clk), .i_reset(i_reset), .i_spi_master_select(spi_master),
    .i_spi_select_n(sel_n), .o_timer_wave(tw), .o_spi_master_out(m_out),
    .o_spi_sck_out(sck_out), .o_spi_slave_out(s_out));

  pbaf_port_b dut (.i_clk_sys(clk), .i_reset(i_reset), .i_portb_dir(dir), .i_portb_out(out),
    .i_global_pullup_disable(pull_off), .i_sleep_inputs_off(sleep), .i_pad_in(pad_in),
    .i_timer2_compare_a_en(ten[3]), .i_timer2_compare_a_out(tw[3]),
    .i_timer1_compare_b_en(ten[2]), .i_timer1_compare_b_out(tw[2]),
    .i_timer1_compare_a_en(ten[1]), .i_timer1_compare_a_out(tw[1]),
    .i_timer0_compare_a_en(ten[0]), .i_timer0_compare_a_out(tw[0]),
    .i_spi_unit_enable(spi_on), .i_spi_master_select(spi_master), .i_spi_slave_out(s_out),
    .i_spi_master_out(m_out), .i_spi_sck_out(sck_out), .i_pin_change_mask(mask),
    .i_pin_change_group1_enable(g1), .o_pad_out(pad_out), .o_pad_oe(pad_oe),
    .o_pad_pullup(pad_pu), .o_pad_in_en(pad_ie), .o_pin_change_src(pcs),
    .o_spi_master_in(m_in), .o_spi_slave_in(s_in), .o_spi_sck_in(sck_in),
    .o_spi_select_n(sel_n));

  // ==========================================================
  // Reference model and scoreboard
  // ==========================================================
  function automatic logic [40:0] model();
    logic [7:0] dir_force, val_force, val_alt, ie, din;
    logic sl, ma;
    sl = spi_on & !spi_master;
    ma = spi_on & spi_master;
    dir_force = {4'h0, ma, sl, sl, sl};
    val_force = {ten, sl, ma, ma, 1'b0};
    val_alt = {tw, s_out, m_out, sck_out, 1'b0};
    ie = (mask & {8{g1}}) | {8{!sleep}};
    din = pad_in & ie;
    model = {~dir_force & dir, (val_force & val_alt) | (~val_force & out),
      (dir_force & out & {8{!pull_off}}) | (~dir_force & ~dir & out & {8{!pull_off}}),
      ie, din, ~ie[0] | pad_in[0]};
  endfunction

  always @(posedge clk) begin
    ev <= 1'b1;
    exp_q <= i_reset ? 41'h00000000001 : model();
  end

  task automatic check(input string what, input logic [7:0] expv, input logic [7:0] got);
    checks_done++;
    if (got !== expv) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h at %0t", what, expv, got, $time);
    end
  endtask

  // Outputs are settled at the falling edge, before new stimulus lands.
  always @(negedge clk) begin
    if (ev) begin
      check("pad_oe", exp_q[40:33], pad_oe);
      check("pad_out", exp_q[32:25], pad_out);
      check("pad_pullup", exp_q[24:17], pad_pu);
      check("pad_in_en", exp_q[16:9], pad_ie);
      check("pin_change_src", exp_q[8:1], pcs);
      check("spi_inputs", {5'h00, exp_q[4:2]}, {5'h00, m_in, s_in, sck_in});
      check("select_n", {7'h00, exp_q[0]}, {7'h00, sel_n});
    end
  end

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic end_test(input string name);
    $display("test %s done, checks so far %0d", name, checks_done);
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Tests
  // ==========================================================
  initial begin
    step(2);
    i_reset <= 1'b0;
    end_test("reset");
    for (int k = 0; k < 4; k++) begin
      dir <= k[1] ? 8'haa : 8'hcc;
      out <= k[1] ? 8'hcc : 8'haa;
      pull_off <= k[0];
      ext <= 8'h96 ^ {8{k[0]}};
      step(2);
    end
    end_test("plain_port");
    for (int k = 0; k < 16; k++) begin
      ten <= k[3:0];
      dir <= k[0] ? 8'hf0 : 8'h50;
      step(3);
    end
    ten <= 4'h0;
    end_test("timer_outputs");
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < 4; k++) begin
        spi_on <= (r != 0);
        spi_master <= (r == 2);
        dir <= k[0] ? 8'h0f : 8'h00;
        out <= k[1] ? 8'h0f : 8'h05;
        pull_off <= k[1] & k[0];
        ext <= {7'h2d, k[1]};
        step(8);
      end
    end
    spi_on <= 1'b0;
    end_test("serial_roles");
    sleep <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      mask <= k[0] ? 8'h3c : 8'hc3;
      g1 <= k[1];
      ext <= 8'h5a ^ {8{k[0]}};
      step(2);
    end
    sleep <= 1'b0;
    step(2);
    end_test("pin_change");
    stop_test();
  end

  // The tests take about 170 cycles; the limit leaves ample margin.
  initial begin
    #8000;
    miscompares++;
    stop_test();
  end
endmodule
`default_nettype wire
